// file: design/rxs_level_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxs_map.svh"

module rxs_level_gate
  import rxs_pkg::*;
(
  input wire logic [3:0] thr_i,
  input wire rxs_level_t rssi_i,
  input wire rxs_level_t floor_i,
  output logic pass_o
);

  logic [11:0] limit;

  // Limit is floor + 3.1 dB * (N - 1); only used when N is nonzero
  always_comb begin
    limit = {2'h0, floor_i} + `RXS_THR_STEP * {8'h00, thr_i - 4'h1};
    if (thr_i == `RXS_THR_MAX_SENS) begin
      pass_o = 1'b1;
    end else begin
      pass_o = ({2'h0, rssi_i} > limit);
    end
  end

endmodule : rxs_level_gate
`default_nettype wire

// file: design/rxs_map.svh
`ifndef RXS_MAP_SVH
`define RXS_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RXS_SYNC_CTRL_ADDR 8'h15
`define RXS_SYNC_CTRL_RESET 8'h00
`define RXS_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------------
// Field positions of rx_sync_control
// ----------------------------------------------------------------------------
`define RXS_DIS_BIT 7
`define RXS_OVR_MSB 6
`define RXS_OVR_LSB 4
`define RXS_THR_MSB 3
`define RXS_THR_LSB 0

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define RXS_OVR_OFF 3'h0
`define RXS_OVR_ON 3'h6
`define RXS_THR_MAX_SENS 4'h0

// ----------------------------------------------------------------------------
// Threshold step: 3.1 dB in level units of 0.1 dB
// ----------------------------------------------------------------------------
`define RXS_THR_STEP 12'h01f

`endif

// file: design/rxs_pkg.sv
package rxs_pkg;

  // --------------------------------------------------------------------------
  // Receive sequencer states, Gray coded along listen -> header -> body
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RXS_LISTEN = 2'b00,
    RXS_HEADER = 2'b01,
    RXS_BODY = 2'b11
  } rxs_state_t;

  typedef logic [7:0] rxs_byte_t;
  typedef logic [9:0] rxs_level_t;

endpackage : rxs_pkg

// file: design/rxs_sync_ctrl.sv
// Overview of operation
// - Disable bit 7 set: no new frame accepted, even while listening.
// - Setting disable bit during a frame leaves that frame to finish normally.
// - Disable bit blocks reception whatever the threshold field holds.
// - Override select bits 6:4 equal to 0 disables all override functions.
// - Override select 6 enables interferer scan, 9dB energy and link-quality checks; code checks only INTERFERER_I and LINK_QUALITY_BAD_I, no energy.
// - Override on: invalid frame or strong interferer abandons frame, restarts sync.
// - Override off: every frame decoded to full header-given length.
// - Frame abandoned by resynchronisation raises no frame-end event.
// - Override works for every modulation and data rate alike.
// - Threshold N nonzero rejects frames below floor plus 3.1dB times (N-1).
// - Threshold 0 receives every frame with valid headers, any strength.
// - While disabled, stay listening and detect no header until cleared.
// - Signal below threshold does not start demodulation.
`timescale 1ns/1ps
`default_nettype none
`include "rxs_map.svh"

module rxs_sync_ctrl
  import rxs_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire rxs_byte_t REG_ADDR_I,
  input wire rxs_byte_t REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  output rxs_byte_t REG_RDATA_O,
  input wire logic LISTEN_STATE_I,
  input wire logic SHR_DETECT_I,
  input wire rxs_level_t RSSI_I,
  input wire rxs_level_t RSSI_FLOOR_VALUE_I,
  input wire logic PHR_VALID_I,
  input wire logic [6:0] PHR_LENGTH_I,
  input wire logic OCTET_STROBE_I,
  input wire logic INTERFERER_I,
  input wire logic LINK_QUALITY_BAD_I,
  output logic DEMOD_START_O,
  output logic BUSY_RX_O,
  output logic FRAME_END_EVENT_O,
  output logic RESYNC_O,
  output logic OVERRIDE_ACTIVE_O
);

  rxs_byte_t rx_sync_control;
  rxs_state_t state;
  logic [6:0] frame_len;
  logic [6:0] octet_cnt;
  logic level_pass;
  logic sync_detect_disable;
  logic [2:0] override_sel;
  logic [3:0] sensitivity_threshold;
  logic override_on;
  logic in_frame;
  logic abort;
  logic accept;
  logic last_octet;

  // --------------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_sync_control <= `RXS_SYNC_CTRL_RESET;
    end else if (CE_I && REG_WE_I && REG_ADDR_I == `RXS_SYNC_CTRL_ADDR) begin
      // Reserved override codes are stored as written; the decode below ignores them
      rx_sync_control <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= `RXS_UNMAPPED_READ;
    end else if (CE_I && REG_RE_I) begin
      if (REG_ADDR_I == `RXS_SYNC_CTRL_ADDR) begin
        REG_RDATA_O <= rx_sync_control;
      end else begin
        REG_RDATA_O <= `RXS_UNMAPPED_READ;
      end
    end
  end

  assign sync_detect_disable = rx_sync_control[`RXS_DIS_BIT];
  assign override_sel = rx_sync_control[`RXS_OVR_MSB:`RXS_OVR_LSB];
  assign sensitivity_threshold = rx_sync_control[`RXS_THR_MSB:`RXS_THR_LSB];

  // Only the one documented code turns the checks on; reserved codes act as off.
  // The checks do not look at modulation or rate, so they apply to all of them.
  assign override_on = (override_sel == `RXS_OVR_ON);

  // --------------------------------------------------------------------------
  // Header acceptance
  // --------------------------------------------------------------------------
  rxs_level_gate u_level_gate (
    .thr_i(sensitivity_threshold),
    .rssi_i(RSSI_I),
    .floor_i(RSSI_FLOOR_VALUE_I),
    .pass_o(level_pass)
  );

  // Disable wins over any threshold value
  assign accept = (state == RXS_LISTEN) && LISTEN_STATE_I && SHR_DETECT_I
                  && !sync_detect_disable && level_pass;

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  assign in_frame = (state != RXS_LISTEN);
  assign abort = override_on && in_frame && (INTERFERER_I || LINK_QUALITY_BAD_I);
  assign last_octet = (state == RXS_BODY) && OCTET_STROBE_I && (octet_cnt == frame_len - 7'h01);

  // The disable bit is not looked at once a frame is under way
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= RXS_LISTEN;
    end else if (CE_I) begin
      case (state)
        RXS_LISTEN: begin
          if (accept) begin
            state <= RXS_HEADER;
          end
        end
        RXS_HEADER: begin
          if (abort) begin
            state <= RXS_LISTEN;
          end else if (PHR_VALID_I) begin
            if (PHR_LENGTH_I == 7'h00) begin
              state <= RXS_LISTEN;
            end else begin
              state <= RXS_BODY;
            end
          end
        end
        RXS_BODY: begin
          if (abort) begin
            state <= RXS_LISTEN;
          end else if (last_octet) begin
            state <= RXS_LISTEN;
          end
        end
        default: begin
          state <= RXS_LISTEN;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      frame_len <= 7'h00;
      octet_cnt <= 7'h00;
    end else if (CE_I) begin
      if (state == RXS_HEADER && PHR_VALID_I) begin
        frame_len <= PHR_LENGTH_I;
        octet_cnt <= 7'h00;
      end else if (state == RXS_BODY && OCTET_STROBE_I) begin
        octet_cnt <= octet_cnt + 7'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event and status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DEMOD_START_O <= 1'b0;
      FRAME_END_EVENT_O <= 1'b0;
      RESYNC_O <= 1'b0;
    end else if (CE_I) begin
      DEMOD_START_O <= accept;
      // An aborted frame never reports its end
      FRAME_END_EVENT_O <= !abort && (last_octet
                           || (state == RXS_HEADER && PHR_VALID_I && PHR_LENGTH_I == 7'h00));
      RESYNC_O <= abort;
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      BUSY_RX_O <= 1'b0;
      OVERRIDE_ACTIVE_O <= 1'b0;
    end else if (CE_I) begin
      BUSY_RX_O <= accept || (in_frame && !abort && !last_octet
                   && !(state == RXS_HEADER && PHR_VALID_I && PHR_LENGTH_I == 7'h00));
      OVERRIDE_ACTIVE_O <= override_on;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence seq_cfg_write;
    CE_I && REG_WE_I && REG_ADDR_I == `RXS_SYNC_CTRL_ADDR;
  endsequence

  sequence seq_cfg_read;
    CE_I && REG_RE_I && !REG_WE_I && REG_ADDR_I == `RXS_SYNC_CTRL_ADDR;
  endsequence

  sequence seq_disturbed;
    CE_I && override_on && in_frame && (INTERFERER_I || LINK_QUALITY_BAD_I);
  endsequence

  sequence seq_last;
    CE_I && last_octet && !abort;
  endsequence

  // A header with length 0 carries no body, so the frame ends at the header
  sequence seq_phr_zero;
    CE_I && state == RXS_HEADER && PHR_VALID_I && PHR_LENGTH_I == 7'h00 && !abort;
  endsequence

  AST_READBACK: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_cfg_write ##1 seq_cfg_read |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("Sync control read did not return last write");

  AST_DIS_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && state == RXS_LISTEN && sync_detect_disable) |=> state == RXS_LISTEN)
    else $error("Left listening while detection disabled");

  AST_DIS_NO_START: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && sync_detect_disable) |=> !DEMOD_START_O)
    else $error("Demodulation started while detection disabled");

  AST_FRAME_KEEPS: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && state == RXS_BODY && !override_on && !last_octet) |=> state == RXS_BODY)
    else $error("Frame cut short without override");

  AST_ABORT: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_disturbed |=> RESYNC_O && !FRAME_END_EVENT_O && state == RXS_LISTEN && !BUSY_RX_O)
    else $error("Disturbed frame not abandoned");

  AST_OFF_NO_RESYNC: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && override_sel != `RXS_OVR_ON) |=> !RESYNC_O)
    else $error("Resync with override off");

  AST_THR_ZERO: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && state == RXS_LISTEN && LISTEN_STATE_I && SHR_DETECT_I && !sync_detect_disable
     && sensitivity_threshold == 4'h0) |=> DEMOD_START_O && BUSY_RX_O && state == RXS_HEADER)
    else $error("Header at full sensitivity not accepted");

  AST_LOW_LEVEL: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && sensitivity_threshold != 4'h0
     && {2'h0, RSSI_I} <= {2'h0, RSSI_FLOOR_VALUE_I} + `RXS_THR_STEP * {8'h00, sensitivity_threshold - 4'h1})
    |=> !DEMOD_START_O)
    else $error("Weak signal started demodulation");

  AST_FRAME_END: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_last |=> FRAME_END_EVENT_O && state == RXS_LISTEN ##1 (!FRAME_END_EVENT_O || !CE_I))
    else $error("Frame end not a single pulse after last octet");

  AST_PHR_ZERO_END: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_phr_zero |=> FRAME_END_EVENT_O && !BUSY_RX_O && state == RXS_LISTEN)
    else $error("Empty frame did not end at its header");

  AST_BUSY_END: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_last |=> !BUSY_RX_O && !RESYNC_O)
    else $error("Busy still set after last octet");

  AST_NO_RESTART: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && in_frame) |=> !DEMOD_START_O)
    else $error("New header accepted during a frame");

  AST_NEEDS_LISTEN: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && !LISTEN_STATE_I) |=> !DEMOD_START_O)
    else $error("Header accepted outside listening state");

  AST_END_IN_FRAME: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && !in_frame) |=> !FRAME_END_EVENT_O)
    else $error("Frame end without a frame");

  AST_RESYNC_PULSE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && RESYNC_O) |=> !RESYNC_O)
    else $error("Resync longer than one cycle");

  AST_OVR_ON: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && override_sel == `RXS_OVR_ON) |=> OVERRIDE_ACTIVE_O)
    else $error("Override select 6 not reported active");

  AST_OVR_OFF: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && override_sel == `RXS_OVR_OFF) |=> !OVERRIDE_ACTIVE_O)
    else $error("Override select 0 not reported off");

  // --------------------------------------------------------------------------
  // Register and enable checks
  // --------------------------------------------------------------------------
  AST_WRITE_TAKES: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    seq_cfg_write |=> rx_sync_control == $past(REG_WDATA_I))
    else $error("Sync control write not stored");

  // Software may poll the last read value, so it must not drift between reads
  AST_RDATA_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !(CE_I && REG_RE_I) |=> $stable(REG_RDATA_O))
    else $error("Read data changed without a read");

  AST_UNMAPPED: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (CE_I && REG_RE_I && REG_ADDR_I != `RXS_SYNC_CTRL_ADDR) |=> REG_RDATA_O == `RXS_UNMAPPED_READ)
    else $error("Unmapped read not zero");

  AST_HOLD_IDLE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !CE_I |=> $stable(rx_sync_control) && $stable(state))
    else $error("State moved while clock enable low");

endmodule : rxs_sync_ctrl
`default_nettype wire

// file: dv/test_rx_sync_detect_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxs_map.svh"

module test_rx_sync_detect_control
  import rxs_pkg::*;
;
  logic clk, rst, we, re, shr, phr, oct, intf, lqb, ce, lsn;
  rxs_byte_t addr, wdata, rdata;
  rxs_level_t rssi;
  logic [6:0] plen;
  logic demod, busy, fend, resync, ovr;
  int mismatches = 0;
  int checked = 0;
  localparam rxs_level_t FLOOR = 10'h064;
  logic [3:0] tn [3] = '{4'h1, 4'h3, 4'hf};

  rxs_sync_ctrl DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .LISTEN_STATE_I(lsn), .SHR_DETECT_I(shr),
    .RSSI_I(rssi), .RSSI_FLOOR_VALUE_I(FLOOR), .PHR_VALID_I(phr), .PHR_LENGTH_I(plen),
    .OCTET_STROBE_I(oct), .INTERFERER_I(intf), .LINK_QUALITY_BAD_I(lqb), .DEMOD_START_O(demod),
    .BUSY_RX_O(busy), .FRAME_END_EVENT_O(fend), .RESYNC_O(resync), .OVERRIDE_ACTIVE_O(ovr));

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------------------
  // Register access and frame stimulus
  // ---------------------------------------------------------------------------
  task automatic wr(input rxs_byte_t a, input rxs_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input rxs_byte_t a, input rxs_byte_t e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    #1 chk("read data", {2'b00, e}, {2'b00, rdata});
  endtask : rd

  // Write then read in the very next cycle, as the bus allows
  task automatic wr_rd(input rxs_byte_t d);
    @(posedge clk);
    addr <= `RXS_SYNC_CTRL_ADDR;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk("read after write", {2'b00, d}, {2'b00, rdata});
  endtask : wr_rd

  // Octets keep coming after an abort, so a late end event would be seen
  task automatic frame(input rxs_level_t lvl, input logic [6:0] len, input int ab_at, input logic [1:0] abv,
                       input logic acc, input logic ab, input logic [8:0] wmid = 9'h000);
    logic fe;
    logic rs;
    fe = 1'b0;
    rs = 1'b0;
    @(posedge clk);
    shr <= 1'b1;
    rssi <= lvl;
    @(posedge clk);
    shr <= 1'b0;
    phr <= 1'b1;
    plen <= len;
    #1 chk("demod start", {9'h0, acc}, {9'h0, demod});
    chk("busy", {9'h0, acc}, {9'h0, busy});
    for (int i = 0; i <= len + 1; i++) begin
      @(posedge clk);
      phr <= 1'b0;
      oct <= (i < len);
      intf <= (i == ab_at) && abv[0];
      lqb <= (i == ab_at) && abv[1];
      we <= (i == 0) && wmid[8];
      addr <= `RXS_SYNC_CTRL_ADDR;
      wdata <= wmid[7:0];
      #1 fe = fe | fend;
      rs = rs | resync;
    end
    @(posedge clk);
    oct <= 1'b0;
    intf <= 1'b0;
    lqb <= 1'b0;
    #1 chk("frame end", {9'h0, acc & ~ab}, {9'h0, fe});
    chk("resync", {9'h0, ab}, {9'h0, rs});
    chk("busy after", 10'h000, {9'h0, busy});
  endtask : frame

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst, we, re, shr, phr, oct, intf, lqb} = 8'h80;
    ce = 1'b1;
    lsn = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    rssi = 10'h000;
    plen = 7'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`RXS_SYNC_CTRL_ADDR, `RXS_SYNC_CTRL_RESET);
    wr(`RXS_SYNC_CTRL_ADDR, 8'ha5);
    rd(`RXS_SYNC_CTRL_ADDR, 8'ha5);
    rd(8'h16, `RXS_UNMAPPED_READ);
    wr_rd(8'h07);
    wr(`RXS_SYNC_CTRL_ADDR, 8'h00);
    frame(10'h000, 7'h02, 1, 2'b11, 1'b1, 1'b0);
    frame(10'h000, 7'h00, -1, 2'b00, 1'b1, 1'b0);
    wr(`RXS_SYNC_CTRL_ADDR, 8'h60);
    rd(`RXS_SYNC_CTRL_ADDR, 8'h60);
    chk("override active", 10'h001, {9'h0, ovr});
    frame(10'h000, 7'h03, 1, 2'b01, 1'b1, 1'b1);
    frame(10'h000, 7'h03, 2, 2'b10, 1'b1, 1'b1);
    frame(10'h3ff, 7'h04, 3, 2'b01, 1'b1, 1'b1);
    // Reserved select codes are stored but behave as off
    wr(`RXS_SYNC_CTRL_ADDR, 8'h50);
    rd(`RXS_SYNC_CTRL_ADDR, 8'h50);
    chk("override active", 10'h000, {9'h0, ovr});
    frame(10'h000, 7'h02, 1, 2'b11, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wr(`RXS_SYNC_CTRL_ADDR, {4'h0, tn[k]});
      frame(FLOOR + 10'h01f * (tn[k] - 4'h1), 7'h01, -1, 2'b00, 1'b0, 1'b0);
      frame(FLOOR + 10'h01f * (tn[k] - 4'h1) + 10'h001, 7'h01, -1, 2'b00, 1'b1, 1'b0);
    end
    wr(`RXS_SYNC_CTRL_ADDR, 8'h80);
    frame(10'h3ff, 7'h02, -1, 2'b00, 1'b0, 1'b0);
    wr(`RXS_SYNC_CTRL_ADDR, 8'h8f);
    frame(10'h3ff, 7'h02, -1, 2'b00, 1'b0, 1'b0);
    wr(`RXS_SYNC_CTRL_ADDR, 8'h00);
    frame(10'h000, 7'h03, -1, 2'b00, 1'b1, 1'b0, 9'h180);
    frame(10'h000, 7'h02, -1, 2'b00, 1'b0, 1'b0);
    wr(`RXS_SYNC_CTRL_ADDR, 8'h00);
    frame(10'h000, 7'h02, -1, 2'b00, 1'b1, 1'b0);
    // Outside the listening state no header is taken
    @(posedge clk);
    lsn <= 1'b0;
    frame(10'h000, 7'h02, -1, 2'b00, 1'b0, 1'b0);
    @(posedge clk);
    lsn <= 1'b1;
    ce <= 1'b0;
    wr(`RXS_SYNC_CTRL_ADDR, 8'h60);
    @(posedge clk);
    ce <= 1'b1;
    rd(`RXS_SYNC_CTRL_ADDR, 8'h00);
    chk("override active", 10'h000, {9'h0, ovr});
    // Reset in mid-run must bring the register back to its reset value
    wr(`RXS_SYNC_CTRL_ADDR, 8'h6f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`RXS_SYNC_CTRL_ADDR, `RXS_SYNC_CTRL_RESET);
    chk("override active", 10'h000, {9'h0, ovr});
    frame(10'h000, 7'h01, -1, 2'b00, 1'b1, 1'b0);
    stop_test();
  end
endmodule : test_rx_sync_detect_control

`default_nettype wire
